// ### src/adc_pkg.sv
/*
 * Package for the audio DMA channel block: register offsets, field positions,
 * reset values, transfer shape constants and state encodings.
 * Assumes a 32-bit register port and a 32-bit memory master port.
 */
package adc_pkg;
    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_PB_CONTROL = 8'h48;
    localparam logic [7:0] OFS_PB_COUNT = 8'h4c;
    localparam logic [7:0] OFS_PB_BASE = 8'h50;
    localparam logic [7:0] OFS_CAP_CONTROL = 8'h54;
    localparam logic [7:0] OFS_CAP_COUNT = 8'h58;
    localparam logic [7:0] OFS_CAP_BASE = 8'h5c;
    // ==================================================================
    // Field positions
    localparam int BIT_DMA_ON = 31;
    localparam int BIT_LINK_BUSY = 30;
    localparam int COUNT_MSB = 15;
    localparam int BASE_LSB = 2;
    // ==================================================================
    // Reset values and transfer shape
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [1:0] WORDS_PER_XFER = 2'h3;
    localparam logic [31:0] XFER_BYTES = 32'h0000_0010;
    // ==================================================================
    // Channel states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MEM = 4'b0010,
        ST_LINK = 4'b0100,
        ST_DONE = 4'b1000
    } adc_state_t;
endpackage : adc_pkg

// ### src/adc_buf.sv
/*
 * Two-entry valid/ready buffer for 16-bit audio slices.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_buf #(
    parameter int WIDTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic wp_q, wp_d, rp_q, rp_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rp_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data_i;
            wp_d = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            cnt_q <= 2'h0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    a_buf_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        cnt_q <= 2'h2) else $error("buffer count above two");
endmodule : adc_buf
`default_nettype wire

// ### src/adc_mem.sv
/*
 * Four-word staging memory for one DMA transfer; read data registered.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_mem #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 32
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdata_d;

    always_comb begin
        rdata_d = mem_q[raddr_i];
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end
endmodule : adc_mem
`default_nettype wire

// ### src/adc_top.sv
/*
 * Audio DMA registers and engines: one playback and one capture channel.
 * Assumes a memory slave that answers one word per mem_ack_i pulse and a
 * codec side that moves 16-bit slices by valid/ready.
 */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Playback starts a memory fetch only while its enable bit 31 is set; a started transfer runs to its end.
// - Playback control bit 30 reads one while the playback engine is not idle.
// - Reserved bits read back zero; writes to them are dropped.
// - Playback count register holds a writable 16-bit transfer count.
// - Each playback transfer fetches four 32-bit words from memory.
// - Playback sends the fetched words to the codec as 16-bit slices.
// - Count one gives one four-word fetch then eight codec slices.
// - Playback base address bits 31:2 writable, bits 1:0 read zero.
// - Capture starts a transfer only while its enable bit 31 is set; others reserved.
// - Capture packs eight codec slices into four words written to memory.
// - Capture count register at 0x58 holds a 16-bit count.
// - Capture base address at 0x5C, bits 31:2 writable, word aligned.
module adc_top (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output logic pb_valid_o,
    input wire logic pb_ready_i,
    output logic [15:0] pb_data_o,
    input wire logic cap_valid_i,
    output logic cap_ready_o,
    input wire logic [15:0] cap_data_i
);
    // ==================================================================
    // Registers
    logic pb_on_q, pb_on_d, cap_on_q, cap_on_d;
    logic [15:0] pb_cnt_q, pb_cnt_d, cap_cnt_q, cap_cnt_d;
    logic [31:2] pb_base_q, pb_base_d, cap_base_q, cap_base_d;
    logic [31:0] rdata_q, rdata_d;
    logic pb_busy;
    // Engine state
    adc_pkg::adc_state_t pb_st_q, pb_st_d, cap_st_q, cap_st_d;
    logic [1:0] pb_wi_q, pb_wi_d, cap_wi_q, cap_wi_d;
    logic [2:0] pb_si_q, pb_si_d, cap_si_q, cap_si_d;
    logic pb_rv_q, pb_rv_d;
    logic [15:0] cap_lo_q, cap_lo_d;
    logic cap_grant;
    // Staging memory and buffer wiring
    logic pb_mwe, cap_mwe;
    logic [1:0] pb_raddr, cap_raddr;
    logic [31:0] pb_word, cap_word, cap_mwdata;
    logic pbb_ready;
    logic [15:0] pb_slice;

    function automatic logic [31:2] next_addr(input logic [31:2] a);
        next_addr = a + adc_pkg::XFER_BYTES[31:2];
    endfunction : next_addr

    assign reg_rdata_o = rdata_q;
    assign pb_busy = (pb_st_q != adc_pkg::ST_IDLE);

    // ==================================================================
    // Register port
    always_comb begin
        pb_on_d = pb_on_q;
        cap_on_d = cap_on_q;
        pb_cnt_d = pb_cnt_q;
        cap_cnt_d = cap_cnt_q;
        pb_base_d = pb_base_q;
        cap_base_d = cap_base_q;
        rdata_d = 32'h0000_0000;
        if (pb_st_q == adc_pkg::ST_DONE) begin
            pb_cnt_d = pb_cnt_q - 16'h0001;
            pb_base_d = next_addr(pb_base_q);
        end
        if (cap_st_q == adc_pkg::ST_DONE) begin
            cap_cnt_d = cap_cnt_q - 16'h0001;
            cap_base_d = next_addr(cap_base_q);
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                adc_pkg::OFS_PB_CONTROL: pb_on_d = reg_wdata_i[adc_pkg::BIT_DMA_ON];
                adc_pkg::OFS_PB_COUNT: pb_cnt_d = reg_wdata_i[adc_pkg::COUNT_MSB:0];
                adc_pkg::OFS_PB_BASE: pb_base_d = reg_wdata_i[31:adc_pkg::BASE_LSB];
                adc_pkg::OFS_CAP_CONTROL: cap_on_d = reg_wdata_i[adc_pkg::BIT_DMA_ON];
                adc_pkg::OFS_CAP_COUNT: cap_cnt_d = reg_wdata_i[adc_pkg::COUNT_MSB:0];
                adc_pkg::OFS_CAP_BASE: cap_base_d = reg_wdata_i[31:adc_pkg::BASE_LSB];
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                adc_pkg::OFS_PB_CONTROL: begin
                    rdata_d[adc_pkg::BIT_DMA_ON] = pb_on_q;
                    rdata_d[adc_pkg::BIT_LINK_BUSY] = pb_busy;
                end
                adc_pkg::OFS_PB_COUNT: rdata_d[adc_pkg::COUNT_MSB:0] = pb_cnt_q;
                adc_pkg::OFS_PB_BASE: rdata_d[31:adc_pkg::BASE_LSB] = pb_base_q;
                adc_pkg::OFS_CAP_CONTROL: rdata_d[adc_pkg::BIT_DMA_ON] = cap_on_q;
                adc_pkg::OFS_CAP_COUNT: rdata_d[adc_pkg::COUNT_MSB:0] = cap_cnt_q;
                adc_pkg::OFS_CAP_BASE: rdata_d[31:adc_pkg::BASE_LSB] = cap_base_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_on_q <= 1'b0;
            cap_on_q <= 1'b0;
            pb_cnt_q <= adc_pkg::RST_REG[15:0];
            cap_cnt_q <= adc_pkg::RST_REG[15:0];
            pb_base_q <= adc_pkg::RST_REG[31:2];
            cap_base_q <= adc_pkg::RST_REG[31:2];
            rdata_q <= adc_pkg::RST_REG;
        end else begin
            pb_on_q <= pb_on_d;
            cap_on_q <= cap_on_d;
            pb_cnt_q <= pb_cnt_d;
            cap_cnt_q <= cap_cnt_d;
            pb_base_q <= pb_base_d;
            cap_base_q <= cap_base_d;
            rdata_q <= rdata_d;
        end
    end

    // ==================================================================
    // Memory master: playback has priority; capture waits while it fetches
    assign cap_grant = (cap_st_q == adc_pkg::ST_MEM) && (pb_st_q != adc_pkg::ST_MEM);
    assign mem_req_o = (pb_st_q == adc_pkg::ST_MEM) || cap_grant;
    assign mem_we_o = cap_grant;
    assign mem_addr_o = cap_grant ? {cap_base_q + {28'h000_0000, cap_wi_q}, 2'b00}
                                  : {pb_base_q + {28'h000_0000, pb_wi_q}, 2'b00};
    assign mem_wdata_o = cap_word;
    assign pb_mwe = (pb_st_q == adc_pkg::ST_MEM) && mem_ack_i;
    assign cap_raddr = cap_wi_q + {1'b0, (cap_grant && mem_ack_i)};

    // ==================================================================
    // Playback engine
    always_comb begin
        pb_st_d = pb_st_q;
        pb_wi_d = pb_wi_q;
        pb_si_d = pb_si_q;
        pb_rv_d = 1'b0;
        case (pb_st_q)
            adc_pkg::ST_IDLE: begin
                if (pb_on_q && pb_cnt_q != 16'h0000) begin
                    pb_st_d = adc_pkg::ST_MEM;
                    pb_wi_d = 2'h0;
                end
            end
            adc_pkg::ST_MEM: begin
                if (mem_ack_i) begin
                    pb_wi_d = pb_wi_q + 2'h1;
                    if (pb_wi_q == adc_pkg::WORDS_PER_XFER) begin
                        pb_st_d = adc_pkg::ST_LINK;
                        pb_si_d = 3'h0;
                        pb_rv_d = 1'b1;
                    end
                end
            end
            adc_pkg::ST_LINK: begin
                // One slice in flight; staging read latency is one cycle
                pb_rv_d = pb_rv_q;
                if (pb_rv_q && pbb_ready) begin
                    pb_si_d = pb_si_q + 3'h1;
                    pb_rv_d = (pb_si_q != 3'h7);
                    if (pb_si_q == 3'h7) begin
                        pb_st_d = adc_pkg::ST_DONE;
                    end
                end
            end
            adc_pkg::ST_DONE: pb_st_d = adc_pkg::ST_IDLE;
            default: pb_st_d = adc_pkg::ST_IDLE;
        endcase
    end

    assign pb_raddr = pb_si_d[2:1];
    assign pb_slice = pb_si_q[0] ? pb_word[31:16] : pb_word[15:0];

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pb_st_q <= adc_pkg::ST_IDLE;
            pb_wi_q <= 2'h0;
            pb_si_q <= 3'h0;
            pb_rv_q <= 1'b0;
        end else begin
            pb_st_q <= pb_st_d;
            pb_wi_q <= pb_wi_d;
            pb_si_q <= pb_si_d;
            pb_rv_q <= pb_rv_d;
        end
    end

    // ==================================================================
    // Capture engine
    assign cap_mwe = (cap_st_q == adc_pkg::ST_LINK) && cap_valid_i && cap_si_q[0];
    assign cap_mwdata = {cap_data_i, cap_lo_q};
    assign cap_ready_o = (cap_st_q == adc_pkg::ST_LINK);

    always_comb begin
        cap_st_d = cap_st_q;
        cap_wi_d = cap_wi_q;
        cap_si_d = cap_si_q;
        cap_lo_d = cap_lo_q;
        case (cap_st_q)
            adc_pkg::ST_IDLE: begin
                if (cap_on_q && cap_cnt_q != 16'h0000) begin
                    cap_st_d = adc_pkg::ST_LINK;
                    cap_si_d = 3'h0;
                end
            end
            adc_pkg::ST_LINK: begin
                if (cap_valid_i) begin
                    cap_si_d = cap_si_q + 3'h1;
                    if (!cap_si_q[0]) begin
                        cap_lo_d = cap_data_i;
                    end
                    if (cap_si_q == 3'h7) begin
                        cap_st_d = adc_pkg::ST_MEM;
                        cap_wi_d = 2'h0;
                    end
                end
            end
            adc_pkg::ST_MEM: begin
                if (cap_grant && mem_ack_i) begin
                    cap_wi_d = cap_wi_q + 2'h1;
                    if (cap_wi_q == adc_pkg::WORDS_PER_XFER) begin
                        cap_st_d = adc_pkg::ST_DONE;
                    end
                end
            end
            adc_pkg::ST_DONE: cap_st_d = adc_pkg::ST_IDLE;
            default: cap_st_d = adc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_st_q <= adc_pkg::ST_IDLE;
            cap_wi_q <= 2'h0;
            cap_si_q <= 3'h0;
            cap_lo_q <= 16'h0000;
        end else begin
            cap_st_q <= cap_st_d;
            cap_wi_q <= cap_wi_d;
            cap_si_q <= cap_si_d;
            cap_lo_q <= cap_lo_d;
        end
    end

    // ==================================================================
    // Instances
    adc_mem #(.DEPTH(4), .WIDTH(32)) u_pb_mem (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .we_i(pb_mwe),
        .waddr_i(pb_wi_q),
        .wdata_i(mem_rdata_i),
        .raddr_i(pb_raddr),
        .rdata_o(pb_word)
    );

    adc_mem #(.DEPTH(4), .WIDTH(32)) u_cap_mem (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .we_i(cap_mwe),
        .waddr_i(cap_si_q[2:1]),
        .wdata_i(cap_mwdata),
        .raddr_i(cap_raddr),
        .rdata_o(cap_word)
    );

    adc_buf #(.WIDTH(16)) u_pb_buf (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pb_rv_q),
        .in_ready_o(pbb_ready),
        .in_data_i(pb_slice),
        .out_valid_o(pb_valid_o),
        .out_ready_i(pb_ready_i),
        .out_data_o(pb_data_o)
    );

    // ==================================================================
    // Checks
    a_pb_gate_on: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ($rose(pb_st_q == adc_pkg::ST_MEM)) |-> $past(pb_on_q))
        else $error("playback fetch started while disabled");
    a_pb_busy_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == adc_pkg::OFS_PB_CONTROL) |=>
        (reg_rdata_o[30] == $past(pb_busy)))
        else $error("busy bit mismatch");
    a_rsv_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $past(reg_rd_i && reg_addr_i == adc_pkg::OFS_PB_BASE) |-> reg_rdata_o[1:0] == 2'b00)
        else $error("reserved address bits not zero");
    a_cap_ctrl_rsv: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == adc_pkg::OFS_CAP_CONTROL) |=> reg_rdata_o[30:0] == 31'h0)
        else $error("capture control reserved bits not zero");
    a_cnt_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_addr_i == adc_pkg::OFS_PB_COUNT) |=>
        pb_cnt_q == $past(reg_wdata_i[15:0]))
        else $error("count write lost");
    a_pb_done_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (pb_st_q == adc_pkg::ST_DONE && !reg_wr_i) |=>
        pb_base_q == $past(pb_base_q) + 30'h4 && pb_cnt_q == $past(pb_cnt_q) - 16'h1)
        else $error("address or count step wrong");
    a_pb_link_after: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (pb_st_q == adc_pkg::ST_MEM && mem_ack_i && pb_wi_q == 2'h3) |=>
        pb_st_q == adc_pkg::ST_LINK)
        else $error("link phase not after four words");
    a_cap_pack: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (cap_st_q == adc_pkg::ST_LINK && cap_valid_i && cap_si_q == 3'h7) |=>
        cap_st_q == adc_pkg::ST_MEM)
        else $error("capture did not move to memory after eight slices");
    a_pb_eight: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (pb_st_q == adc_pkg::ST_LINK && pb_rv_q && pbb_ready && pb_si_q == 3'h7) |=>
        pb_st_q == adc_pkg::ST_DONE)
        else $error("playback did not end after eight slices");
    a_base_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_addr_i == adc_pkg::OFS_CAP_BASE) |=>
        cap_base_q == $past(reg_wdata_i[31:2]))
        else $error("capture base write lost");
endmodule : adc_top
`default_nettype wire

// ### sim/adc_mem_model.sv
/*
 * Memory slave model for the audio DMA block: acks quickly or slowly, logs writes.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_mem_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [31:0] wr_addr [0:7];
    logic [31:0] wr_data [0:7];
    int n_wr;
    int n_rd;
    int wait_q;
    // ==========================================
    // Slave answer
    // Read data toggles outside an ack so a stale word is never taken as valid
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h0000_0000;
            wait_q <= 0;
            n_wr <= 0;
            n_rd <= 0;
        end else begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i === 1'b1 && !mem_ack_o) begin
                if (wait_q < (slow_i ? 3 : 0)) begin
                    wait_q <= wait_q + 1;
                end else begin
                    wait_q <= 0;
                    mem_ack_o <= 1'b1;
                    if (mem_we_i) begin
                        wr_addr[n_wr % 8] <= mem_addr_i;
                        wr_data[n_wr % 8] <= mem_wdata_i;
                        n_wr <= n_wr + 1;
                    end else begin
                        mem_rdata_o <= {mem_addr_i[15:0], ~mem_addr_i[15:0]};
                        n_rd <= n_rd + 1;
                    end
                end
            end
        end
    end
endmodule : adc_mem_model
`default_nettype wire

// ### sim/adc_top_tb.sv
/*
 * Self-checking bench for adc_top: register port, playback and capture DMA.
 * Assumes adc_pkg offsets and the memory model beside the design.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_top_tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic mem_req_o, mem_we_o, mem_ack_i, pb_valid_o, cap_ready_o;
    logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
    logic pb_ready_i = 1'b0;
    logic [15:0] pb_data_o;
    logic cap_valid_i = 1'b0;
    logic [15:0] cap_data_i = 16'h0000;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic [31:0] seed = 32'h0000_0006;
    logic [31:0] sink_s = 32'h0000_0006;
    logic [15:0] pbq [$];
    logic [15:0] sl [0:7];
    logic [31:0] base;
    int n_errors = 0;
    int n_checks = 0;

    adc_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
        .mem_rdata_i(mem_rdata_i), .pb_valid_o(pb_valid_o), .pb_ready_i(pb_ready_i),
        .pb_data_o(pb_data_o), .cap_valid_i(cap_valid_i), .cap_ready_o(cap_ready_o),
        .cap_data_i(cap_data_i));
    adc_mem_model mem_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

    always #12.5 clock_i = ~clock_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [31:0] rnd();
        seed = xs(seed);
        return seed;
    endfunction : rnd
    // Slice i is the low then the high half of word i/2 counted from the base
    function automatic logic [15:0] exp_slice(input logic [31:0] b, input int i);
        logic [31:0] a;
        a = b + 32'(4 * (i / 2));
        return (i % 2) ? a[15:0] : ~a[15:0];
    endfunction : exp_slice

    // ==========================================
    // Codec sink with random stalls
    always @(posedge clock_i) begin
        sink_s = xs(sink_s);
        pb_ready_i <= !stall && sink_s[0];
        if (pb_valid_o === 1'b1 && pb_ready_i) pbq.push_back(pb_data_o);
    end

    // ==========================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16
    task automatic timed_out();
        n_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test();
    endtask : timed_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk32(d, e);
    endtask : rchk
    task automatic wait_idle();
        logic [31:0] d;
        int k;
        d = 32'hffff_ffff;
        for (k = 0; k < 400 && d[30] !== 1'b0; k++) rd(adc_pkg::OFS_PB_CONTROL, d);
        if (d[30] !== 1'b0) timed_out();
    endtask : wait_idle
    task automatic wait_slices(input int n);
        int k;
        for (k = 0; k < 5000 && pbq.size() < n; k++) @(posedge clock_i);
        if (pbq.size() < n) timed_out();
    endtask : wait_slices
    task automatic send(input logic [15:0] d);
        int k;
        @(posedge clock_i);
        cap_valid_i <= 1'b1;
        cap_data_i <= d;
        k = 0;
        do begin
            @(negedge clock_i);
            k++;
        end while (cap_ready_o !== 1'b1 && k < 200);
        @(posedge clock_i);
        cap_valid_i <= 1'b0;
        if (k >= 200) timed_out();
    endtask : send

    // ==========================================
    // Main sequence
    logic [7:0] ofs [0:3] = '{adc_pkg::OFS_PB_COUNT, adc_pkg::OFS_PB_BASE,
        adc_pkg::OFS_CAP_COUNT, adc_pkg::OFS_CAP_BASE};
    logic [31:0] msk [0:3] = '{32'h0000_ffff, 32'hffff_fffc, 32'h0000_ffff, 32'hffff_fffc};
    logic [31:0] v;
    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) rchk(ofs[i], 32'h0000_0000);
        rchk(adc_pkg::OFS_PB_CONTROL, 32'h0000_0000);
        rchk(adc_pkg::OFS_CAP_CONTROL, 32'h0000_0000);
        wr(8'h60, rnd());
        rchk(8'h60, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            v = (i < 4) ? 32'hffff_ffff : rnd();
            wr(ofs[i % 4], v & msk[i % 4]);
            rchk(ofs[i % 4], v & msk[i % 4]);
        end
        // Playback: stalled sink fills the buffer, disable lands mid transfer
        base = rnd() & 32'hffff_fffc;
        wr(adc_pkg::OFS_PB_BASE, base);
        wr(adc_pkg::OFS_PB_COUNT, 32'h0000_0003);
        repeat (20) @(posedge clock_i);
        chk32({31'h0, mem_req_o}, 32'h0000_0000);
        slow <= 1'b1;
        stall <= 1'b1;
        wr(adc_pkg::OFS_PB_CONTROL, 32'h8000_0000);
        rchk(adc_pkg::OFS_PB_CONTROL, 32'hc000_0000);
        wr(adc_pkg::OFS_PB_CONTROL, 32'h0000_0000);
        repeat (40) @(posedge clock_i);
        stall <= 1'b0;
        wait_slices(8);
        wait_idle();
        repeat (30) @(posedge clock_i);
        chk32(32'(pbq.size()), 32'h0000_0008);
        rchk(adc_pkg::OFS_PB_COUNT, 32'h0000_0002);
        rchk(adc_pkg::OFS_PB_BASE, base + 32'h0000_0010);
        wr(adc_pkg::OFS_PB_CONTROL, 32'h8000_0000);
        wait_slices(24);
        wait_idle();
        rchk(adc_pkg::OFS_PB_CONTROL, 32'h8000_0000);
        rchk(adc_pkg::OFS_PB_COUNT, 32'h0000_0000);
        rchk(adc_pkg::OFS_PB_BASE, base + 32'h0000_0030);
        chk32(32'(mem_u.n_rd), 32'h0000_000c);
        chk32(32'(pbq.size()), 32'h0000_0018);
        for (int i = 0; i < 24; i++) chk16(pbq[i], exp_slice(base, i));
        wr(adc_pkg::OFS_PB_CONTROL, 32'h0000_0000);
        // Capture: eight slices packed into four words
        slow <= 1'b0;
        base = rnd() & 32'hffff_fffc;
        wr(adc_pkg::OFS_CAP_BASE, base);
        wr(adc_pkg::OFS_CAP_COUNT, 32'h0000_0001);
        wr(adc_pkg::OFS_CAP_CONTROL, 32'h8000_0000);
        rchk(adc_pkg::OFS_CAP_CONTROL, 32'h8000_0000);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            sl[i] = v[15:0];
            send(sl[i]);
        end
        for (int k = 0; k < 200 && mem_u.n_wr < 4; k++) @(posedge clock_i);
        if (mem_u.n_wr < 4) timed_out();
        for (int i = 0; i < 4; i++) begin
            chk32(mem_u.wr_addr[i], base + 32'(4 * i));
            chk32(mem_u.wr_data[i], {sl[2 * i + 1], sl[2 * i]});
        end
        rchk(adc_pkg::OFS_CAP_COUNT, 32'h0000_0000);
        rchk(adc_pkg::OFS_CAP_BASE, base + 32'h0000_0010);
        wr(adc_pkg::OFS_CAP_CONTROL, 32'h0000_0000);
        rchk(adc_pkg::OFS_CAP_CONTROL, 32'h0000_0000);
        // Reset after both runs must also clear the advanced base addresses
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) rchk(ofs[i], 32'h0000_0000);
        stop_test();
    end
endmodule : adc_top_tb
`default_nettype wire
